// [rps_pkg.sv]
// Constants and types shared by the read parameter command block.
package rps_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_RP_PERSIST = 8'h65;
  localparam logic [7:0] OP_SET_RP_VOL_A = 8'hC0;
  localparam logic [7:0] OP_SET_RP_VOL_B = 8'h63;
  localparam logic [7:0] OP_SET_EXT_PERSIST = 8'h85;
  localparam logic [7:0] OP_SET_EXT_VOL = 8'h83;
  localparam logic [7:0] OP_RDBACK_RP = 8'h61;
  localparam logic [7:0] OP_RDBACK_EXT = 8'h81;
  localparam logic [7:0] OP_CLEAR_EXT_ERR = 8'h82;
  localparam logic [7:0] OP_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RP_WRAP_EN = 2;
  localparam int RP_DUMMY_LSB = 3;
  localparam int RP_DUMMY_MSB = 6;
  localparam int RP_PIN_SEL = 7;
  localparam int EXT_WIP = 0;
  localparam int EXT_PROT_ERR = 2;
  localparam int EXT_PROG_ERR = 3;
  localparam int EXT_ERASE_ERR = 4;
  localparam int EXT_DS_LSB = 5;
  localparam logic [7:0] RP_RESET = 8'h00;
  localparam logic [2:0] DS_HALF = 3'h7;
  localparam logic [2:0] DS_EIGHTH = 3'h1;
  // Serial clock idles low and the other pins idle high, so the edge
  // detectors see no false edge when the synchroniser leaves reset.
  localparam logic [7:0] PIN_IDLE = 8'h7F;

  // ----------------------------------------------------------------
  // Timing counts in serial clocks
  // ----------------------------------------------------------------
  localparam logic [2:0] SPI_LAST_CLK = 3'h7;
  localparam logic [2:0] QPI_LAST_CLK = 3'h1;
  localparam logic [4:0] SIG_DUMMY_SPI = 5'h18;
  localparam logic [4:0] SIG_DUMMY_QPI = 5'h06;
  localparam logic [4:0] FAST_DUMMY_DEF = 5'h08;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_DATA = 6'h04,
    ST_ADDR = 6'h08,
    ST_DUM = 6'h10,
    ST_OUT = 6'h20
  } rps_state_t;

  typedef enum logic [1:0] {
    SRC_RP = 2'h0,
    SRC_EXT = 2'h1,
    SRC_SIG = 2'h2,
    SRC_ARR = 2'h3
  } rps_src_t;

  typedef struct packed {
    logic erase;
    logic prog;
    logic prot;
  } rps_err_t;

  typedef struct packed {
    logic rd;
    logic [23:0] addr;
  } rps_arr_t;

  // Last serial clock of a byte for the current command mode.
  function automatic logic [2:0] byte_last(input logic qpi);
    byte_last = qpi ? QPI_LAST_CLK : SPI_LAST_CLK;
  endfunction : byte_last

  // Offset mask inside a wrap boundary of 8, 16, 32 or 64 bytes.
  function automatic logic [7:0] wrap_mask(input logic [1:0] len);
    wrap_mask = 8'((8'h08 << len) - 8'h01);
  endfunction : wrap_mask

endpackage : rps_pkg

// [rps_pin_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/100ps
module rps_pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  import rps_pkg::*;

  logic [W-1:0] meta_reg;

  // Only the second stage is visible outside this module.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule : rps_pin_sync

// [rps_wrap_addr.sv]
// Next read address, continuous or wrapping inside a burst boundary.
`timescale 1ns/100ps
module rps_wrap_addr (
  input wire logic [23:0] addr_in,
  input wire logic [2:0] wrap_in,
  output logic [23:0] next_out
);
  import rps_pkg::*;

  logic [23:0] inc;
  logic [7:0] mask;
  logic [7:0] low_wrap;

  assign inc = addr_in + 24'h00_0001;
  assign mask = wrap_mask(wrap_in[1:0]);
  assign low_wrap = (addr_in[7:0] & ~mask) | (inc[7:0] & mask);
  // The boundary sits inside one page, so the page bits never move.
  assign next_out = wrap_in[RP_WRAP_EN] ?
                    {addr_in[23:8], low_wrap} : inc;

endmodule : rps_wrap_addr

// [rps_cmd_ctrl.sv]
// Read parameter command interpreter on the serial flash pins.
`timescale 1ns/100ps
module rps_cmd_ctrl #(
  parameter bit HAS_DED_RESET = 1'b0,
  // Arbitrary value, not tied to any product.
  parameter logic [7:0] SIGNATURE_BYTE = 8'h5A
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input wire logic hold_reset_n_in,
  input wire logic ded_reset_n_in,
  input wire logic qpi_mode_in,
  input wire logic write_in_progress_in,
  input wire logic soft_reset_in,
  input wire rps_pkg::rps_err_t err_set_in,
  input wire logic [7:0] array_data_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  output rps_pkg::rps_arr_t array_req_out,
  output logic [2:0] drive_strength_out,
  output logic [7:0] read_params_out,
  output logic hold_active_out
);
  import rps_pkg::*;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [7:0] pins;
  logic s_sclk, s_cs_n, s_hold_n, s_ded_n;
  logic [3:0] s_io;
  logic sclk_d_reg, cs_d_reg;

  rps_pin_sync #(.W(8), .INIT(PIN_IDLE)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in({sclk_in, cs_n_in, hold_reset_n_in, ded_reset_n_in,
             io_in}),
    .sync_out(pins)
  );

  assign {s_sclk, s_cs_n, s_hold_n, s_ded_n, s_io} = pins;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  rps_state_t state_reg, state_next, opc_state, addr_state;
  rps_src_t src_reg, op_src;
  logic [2:0] cnt_reg, ocnt_reg, last;
  logic [7:0] sh_reg, sh_next, cmd_reg, data_reg, osr_reg;
  logic [7:0] rp_vol_reg, rp_nv_reg, ext_rd, nb, cur;
  logic [2:0] ds_vol_reg, ds_nv_reg;
  rps_err_t err_reg;
  logic op_ok_reg, data_ok_reg;
  logic [1:0] acnt_reg;
  logic [4:0] dcnt_reg, fast_dummy;
  logic [23:0] wrap_next;
  rps_arr_t arr_reg;
  logic [3:0] io_reg, oe_reg;
  logic hold_reg;

  // ----------------------------------------------------------------
  // Shared pin, resets and serial clock edges
  // ----------------------------------------------------------------
  logic pin_is_reset, hold_now, hw_rst, reload;
  logic rise, fall, cs_rise, byte_done, take;

  assign pin_is_reset = !HAS_DED_RESET && rp_vol_reg[RP_PIN_SEL];
  assign hold_now = !pin_is_reset && !s_hold_n;
  // A separate reset pin always resets; bit 7 is not consulted.
  assign hw_rst = HAS_DED_RESET ? !s_ded_n :
                  (pin_is_reset && !s_hold_n);
  assign reload = hw_rst || soft_reset_in;
  assign rise = s_sclk && !sclk_d_reg && !s_cs_n && !hold_now;
  assign fall = !s_sclk && sclk_d_reg && !s_cs_n && !hold_now;
  assign cs_rise = s_cs_n && !cs_d_reg;
  assign last = byte_last(qpi_mode_in);
  assign sh_next = qpi_mode_in ? {sh_reg[3:0], s_io} :
                   {sh_reg[6:0], s_io[0]};
  assign byte_done = rise && (cnt_reg == last);

  // ----------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------
  logic is_set, is_persist, is_rdback, is_read, op_refused;

  assign is_persist = (sh_next == OP_SET_RP_PERSIST) ||
                      (sh_next == OP_SET_EXT_PERSIST);
  assign is_set = is_persist || (sh_next == OP_SET_RP_VOL_A) ||
                  (sh_next == OP_SET_RP_VOL_B) ||
                  (sh_next == OP_SET_EXT_VOL);
  // 81h stays served during a write so the host can poll it.
  assign is_rdback = (sh_next == OP_RDBACK_RP) ||
                     (sh_next == OP_RDBACK_EXT);
  assign is_read = (sh_next == OP_READ) || (sh_next == OP_FAST_READ);
  assign op_refused = write_in_progress_in &&
                      (is_persist || sh_next == OP_SIGNATURE);
  assign op_src = (sh_next == OP_RDBACK_RP) ? SRC_RP :
                  (sh_next == OP_RDBACK_EXT) ? SRC_EXT :
                  (sh_next == OP_SIGNATURE) ? SRC_SIG : SRC_ARR;
  // A refused or unknown opcode leaves the frame idle until CS rises.
  assign opc_state = op_refused ? ST_IDLE :
                     is_set ? ST_DATA :
                     is_rdback ? ST_OUT :
                     (sh_next == OP_SIGNATURE) ? ST_DUM :
                     is_read ? ST_ADDR : ST_IDLE;
  assign addr_state = (cmd_reg == OP_FAST_READ) ? ST_DUM : ST_OUT;
  assign fast_dummy = (rp_vol_reg[RP_DUMMY_MSB:RP_DUMMY_LSB] == 4'h0) ?
                      FAST_DUMMY_DEF :
                      {1'b0, rp_vol_reg[RP_DUMMY_MSB:RP_DUMMY_LSB]};

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  // After an opcode the idle state marks a frame that only waits for CS.
  logic frame_seen_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!s_cs_n && !frame_seen_reg) state_next = ST_OPC;
      end
      ST_OPC: begin
        if (byte_done) state_next = opc_state;
      end
      ST_DATA: begin
        if (byte_done) state_next = ST_IDLE;
      end
      ST_ADDR: begin
        if (byte_done && acnt_reg == 2'h2) state_next = addr_state;
      end
      ST_DUM: begin
        if (rise && dcnt_reg == 5'h01) state_next = ST_OUT;
      end
      ST_OUT: state_next = ST_OUT;
      default: state_next = ST_IDLE;
    endcase
    if (s_cs_n || reload) state_next = ST_IDLE;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      frame_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sclk_d_reg <= s_sclk;
      cs_d_reg <= s_cs_n;
      frame_seen_reg <= !s_cs_n && (frame_seen_reg ||
                        state_reg != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || s_cs_n) begin
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      acnt_reg <= 2'h0;
      dcnt_reg <= 5'h00;
    end else if (rise) begin
      cnt_reg <= (cnt_reg == last) ? 3'h0 : 3'(cnt_reg + 3'h1);
      sh_reg <= sh_next;
      if (state_reg == ST_ADDR && byte_done) acnt_reg <= 2'(acnt_reg + 2'h1);
      if (state_reg == ST_OPC && byte_done) begin
        dcnt_reg <= qpi_mode_in ? SIG_DUMMY_QPI : SIG_DUMMY_SPI;
      end else if (state_reg == ST_ADDR && byte_done) begin
        dcnt_reg <= fast_dummy;
      end else if (state_reg == ST_DUM) begin
        dcnt_reg <= 5'(dcnt_reg - 5'h01);
      end
    end
  end

  // Frame flags; a set only counts once the whole data byte is in.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cs_rise || reload) begin
      op_ok_reg <= 1'b0;
      data_ok_reg <= 1'b0;
      cmd_reg <= 8'h00;
      src_reg <= SRC_RP;
    end else if (byte_done && state_reg == ST_OPC) begin
      op_ok_reg <= !op_refused;
      cmd_reg <= sh_next;
      src_reg <= op_src;
    end else if (byte_done && state_reg == ST_DATA) begin
      data_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      data_reg <= 8'h00;
    end else if (byte_done && state_reg == ST_DATA) begin
      data_reg <= sh_next;
    end
  end

  // ----------------------------------------------------------------
  // Commit on chip select rising
  // ----------------------------------------------------------------
  logic commit, wr_rp_nv, wr_rp_v, wr_ext_nv, wr_ext_v, clr_err;

  assign commit = cs_rise && op_ok_reg && !reload;
  assign wr_rp_nv = commit && data_ok_reg &&
                    cmd_reg == OP_SET_RP_PERSIST;
  assign wr_rp_v = commit && data_ok_reg &&
                   (cmd_reg == OP_SET_RP_VOL_A ||
                    cmd_reg == OP_SET_RP_VOL_B);
  assign wr_ext_nv = commit && data_ok_reg &&
                     cmd_reg == OP_SET_EXT_PERSIST;
  assign wr_ext_v = commit && data_ok_reg && cmd_reg == OP_SET_EXT_VOL;
  assign clr_err = commit && cmd_reg == OP_CLEAR_EXT_ERR;

  // Wrap, length and dummy bits are kept as written, so wrap lasts
  // until a later set or a reset changes them.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rp_nv_reg <= RP_RESET;
      rp_vol_reg <= RP_RESET;
      ds_nv_reg <= DS_HALF;
      ds_vol_reg <= DS_HALF;
    end else begin
      if (reload) begin
        rp_vol_reg <= rp_nv_reg;
        ds_vol_reg <= ds_nv_reg;
      end else begin
        if (wr_rp_nv || wr_rp_v) rp_vol_reg <= data_reg;
        if (wr_ext_nv || wr_ext_v) ds_vol_reg <= data_reg[7:5];
      end
      if (wr_rp_nv) rp_nv_reg <= data_reg;
      if (wr_ext_nv) ds_nv_reg <= data_reg[7:5];
    end
  end

  // A new error in the clearing cycle survives the clear.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      err_reg <= '0;
    end else begin
      err_reg <= (err_reg & ~{3{clr_err}}) | err_set_in;
    end
  end

  // ----------------------------------------------------------------
  // Output shifting and array addressing
  // ----------------------------------------------------------------
  assign ext_rd = {ds_vol_reg, err_reg.erase, err_reg.prog,
                   err_reg.prot, 1'b0, write_in_progress_in};
  assign nb = (src_reg == SRC_RP) ? rp_vol_reg :
              (src_reg == SRC_EXT) ? ext_rd :
              (src_reg == SRC_SIG) ? SIGNATURE_BYTE :
              array_data_in;
  assign take = fall && state_reg == ST_OUT && ocnt_reg == 3'h0;
  assign cur = (ocnt_reg == 3'h0) ? nb : osr_reg;

  rps_wrap_addr u_wrap (
    .addr_in(arr_reg.addr),
    .wrap_in(rp_vol_reg[2:0]),
    .next_out(wrap_next)
  );

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || s_cs_n) begin
      ocnt_reg <= 3'h0;
      osr_reg <= 8'h00;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (fall && state_reg == ST_OUT) begin
      ocnt_reg <= (ocnt_reg == last) ? 3'h0 : 3'(ocnt_reg + 3'h1);
      osr_reg <= qpi_mode_in ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
      io_reg <= qpi_mode_in ? cur[7:4] : {2'b00, cur[7], 1'b0};
      oe_reg <= qpi_mode_in ? 4'hF : 4'h2;
    end
  end

  // Every read opcode goes through the same wrap-aware stepping.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      arr_reg <= '0;
    end else begin
      arr_reg.rd <= take && src_reg == SRC_ARR;
      if (byte_done && state_reg == ST_ADDR) begin
        arr_reg.addr <= {arr_reg.addr[15:0], sh_next};
      end else if (take && src_reg == SRC_ARR) begin
        arr_reg.addr <= wrap_next;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= hold_now;
    end
  end

  assign io_out = io_reg;
  assign io_oe_out = oe_reg;
  assign array_req_out = arr_reg;
  assign drive_strength_out = ds_vol_reg;
  assign read_params_out = rp_vol_reg;
  assign hold_active_out = hold_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  nv_copy_a: assert property (wr_rp_nv |=>
    rp_vol_reg == rp_nv_reg && rp_nv_reg == $past(data_reg))
    else $error("persistent set did not load both copies");
  vol_only_a: assert property (wr_rp_v |=>
    $stable(rp_nv_reg) && rp_vol_reg == $past(data_reg))
    else $error("volatile set touched persistent copy");
  ext_copy_a: assert property (wr_ext_nv |=>
    ds_vol_reg == ds_nv_reg)
    else $error("extended persistent set missed volatile copy");
  short_frame_a: assert property (cs_rise && !data_ok_reg && !reload
    |=> $stable(rp_vol_reg) && $stable(rp_nv_reg))
    else $error("short set frame changed a register");
  err_hold_a: assert property (err_reg.prot && !clr_err |=>
    err_reg.prot)
    else $error("error bit dropped without clear");
  err_clear_a: assert property (clr_err && err_set_in == '0 |=>
    err_reg == '0)
    else $error("clear command left an error bit");
  sig_busy_a: assert property (state_reg == ST_OPC && byte_done &&
    sh_next == OP_SIGNATURE && write_in_progress_in && !s_cs_n &&
    !reload |=> state_reg == ST_IDLE && !op_ok_reg [*2])
    else $error("signature accepted during write");
  reload_a: assert property (reload |=>
    rp_vol_reg == $past(rp_nv_reg) && ds_vol_reg == $past(ds_nv_reg))
    else $error("reset did not reload volatile copies");
  wrap_page_a: assert property (arr_reg.rd && rp_vol_reg[RP_WRAP_EN]
    && $past(state_reg) == ST_OUT |-> arr_reg.addr[23:6] ==
    $past(arr_reg.addr[23:6]))
    else $error("wrapped read left its boundary");
  linear_a: assert property (arr_reg.rd && !rp_vol_reg[RP_WRAP_EN]
    |-> arr_reg.addr == 24'($past(arr_reg.addr) + 24'h00_0001))
    else $error("continuous read did not step by one");
  rdback_a: assert property (take && src_reg == SRC_RP &&
    !qpi_mode_in |=> io_reg[1] == $past(rp_vol_reg[7]))
    else $error("read-back did not start with volatile MSB");

  wrap_read_c: cover property (arr_reg.rd && rp_vol_reg[RP_WRAP_EN]);
  sig_out_c: cover property (take && src_reg == SRC_SIG);
  err_clear_c: cover property (clr_err && err_reg != '0);

endmodule : rps_cmd_ctrl

// [rps_host_model.sv]
// Host controller model that drives the serial flash command pins.
`timescale 1ns/100ps
module rps_host_model (
  input wire logic ref_clk_in,
  input wire logic [3:0] io_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out
);
  // ----------------------------------------------------------------
  // Pin sequencing
  // ----------------------------------------------------------------
  // The serial clock idles low and stands still between frames.
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'h0;
  end

  task automatic half();
    repeat (8) @(negedge ref_clk_in);
  endtask : half

  task automatic start();
    @(negedge ref_clk_in);
    cs_n_out <= 1'b0;
    half();
  endtask : start

  // A short clock count cuts a frame or gives dummy clocks.
  task automatic xfer(input logic qpi, input int nclk,
                      input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nclk; i++) begin
      io_out <= qpi ? tx[7 - 4 * (i % 2) -: 4] : {3'h0, tx[7 - (i % 8)]};
      half();
      sclk_out <= 1'b1;
      rx = qpi ? {rx[3:0], io_in} : {rx[6:0], io_in[1]};
      half();
      sclk_out <= 1'b0;
    end
  endtask : xfer

  // Released data lines show the inverse so stale values never match.
  task automatic stop();
    @(negedge ref_clk_in);
    cs_n_out <= 1'b1;
    io_out <= ~io_out;
    repeat (16) @(negedge ref_clk_in);
  endtask : stop

endmodule : rps_host_model

// [tb_top.sv]
// Self-checking testbench for the read parameter command block.
`timescale 1ns/100ps
module tb_top;
  import rps_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Arbitrary signature, not tied to any product.
  localparam logic [7:0] SIG = 8'h3C;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hold_n = 1'b1;
  logic ded_n = 1'b1;
  logic [7:0] rparams_b;
  logic qpi = 1'b0;
  logic write_in_progress = 1'b0;
  logic soft_rst = 1'b0;
  logic oe_seen = 1'b0;
  rps_err_t err_set = '0;
  rps_err_t e;
  rps_arr_t arr_req;
  logic sclk, cs_n, hold_act;
  logic [3:0] host_io, dut_io, dut_oe, io_wire;
  logic [2:0] drive;
  logic [7:0] rparams, rp, op, rx;
  logic [23:0] a;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'h0307_34c2;

  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (dut_oe !== 4'h0) oe_seen <= 1'b1;
  assign io_wire = (dut_io & dut_oe) | (host_io & ~dut_oe);

  function automatic logic [7:0] pat(input logic [23:0] x);
    pat = x[7:0] ^ x[15:8] ^ 8'h5D;
  endfunction : pat

  // Wrap keeps the count inside an aligned burst of the page.
  function automatic logic [23:0] nxt(input logic [23:0] x,
                                      input logic [2:0] w);
    logic [7:0] m;
    m = (8'h08 << w[1:0]) - 8'h01;
    nxt = w[2] ? {x[23:8], (x[7:0] & ~m) | ((x[7:0] + 8'h01) & m)}
               : x + 24'h00_0001;
  endfunction : nxt

  rps_cmd_ctrl #(.HAS_DED_RESET(1'b0), .SIGNATURE_BYTE(SIG)) dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .io_in(io_wire), .hold_reset_n_in(hold_n),
    .ded_reset_n_in(ded_n), .qpi_mode_in(qpi),
    .write_in_progress_in(write_in_progress), .soft_reset_in(soft_rst),
    .err_set_in(err_set), .array_data_in(pat(arr_req.addr)),
    .io_out(dut_io), .io_oe_out(dut_oe), .array_req_out(arr_req),
    .drive_strength_out(drive), .read_params_out(rparams),
    .hold_active_out(hold_act));

  // Variant with a separate reset pin; it listens to the same frames.
  rps_cmd_ctrl #(.HAS_DED_RESET(1'b1), .SIGNATURE_BYTE(SIG)) dut_ded (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .io_in(io_wire), .hold_reset_n_in(hold_n),
    .ded_reset_n_in(ded_n), .qpi_mode_in(qpi),
    .write_in_progress_in(write_in_progress), .soft_reset_in(soft_rst),
    .err_set_in(err_set), .array_data_in(8'h00),
    .io_out(), .io_oe_out(), .array_req_out(),
    .drive_strength_out(), .read_params_out(rparams_b),
    .hold_active_out());

  rps_host_model host (.ref_clk_in(ref_clk_in), .io_in(io_wire),
    .sclk_out(sclk), .cs_n_out(cs_n), .io_out(host_io));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] c, input int n, input logic [7:0] d);
    logic [7:0] r;
    host.start();
    host.xfer(qpi, qpi ? 2 : 8, c, r);
    if (n > 0) host.xfer(qpi, n, d, r);
    host.stop();
  endtask : cmd

  // Reads two bytes so that the repeat of the answer is seen too.
  task automatic rd_rep(input logic [7:0] c, input int nd,
                        input logic [7:0] exp);
    logic [7:0] r;
    int fb;
    fb = qpi ? 2 : 8;
    host.start();
    host.xfer(qpi, fb, c, r);
    repeat (nd) host.xfer(qpi, fb, 8'h00, r);
    repeat (2) begin
      host.xfer(qpi, fb, 8'h00, r);
      check(r, exp);
    end
    host.stop();
  endtask : rd_rep

  task automatic pulse_soft();
    @(negedge ref_clk_in) soft_rst = 1'b1;
    @(negedge ref_clk_in) soft_rst = 1'b0;
    repeat (4) @(negedge ref_clk_in);
  endtask : pulse_soft

  task automatic conclude();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (100000) @(posedge ref_clk_in);
    num_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    check(rparams, RP_RESET);
    check({5'h00, drive}, {5'h00, DS_HALF});
    cmd(OP_SET_RP_PERSIST, 8, 8'h05);
    cmd(OP_SET_RP_VOL_B, 8, 8'h06);
    rd_rep(OP_RDBACK_RP, 0, 8'h06);
    cmd(OP_SET_RP_VOL_A, 4, 8'h07);
    check(rparams, 8'h06);
    pulse_soft();
    check(rparams, 8'h05);
    cmd(OP_SET_EXT_PERSIST, 8, {DS_EIGHTH, 5'h00});
    check({5'h00, drive}, {5'h00, DS_EIGHTH});
    qpi = 1'b1;
    cmd(OP_SET_EXT_VOL, 2, 8'h80);
    qpi = 1'b0;
    rd_rep(OP_RDBACK_EXT, 0, 8'h80);
    pulse_soft();
    check({5'h00, drive}, {5'h00, DS_EIGHTH});
    e = 3'($random(seed)) | 3'h1;
    @(negedge ref_clk_in) err_set = e;
    @(negedge ref_clk_in) err_set = '0;
    write_in_progress = 1'b1;
    rd_rep(OP_RDBACK_EXT, 0, {DS_EIGHTH, e, 2'h1});
    oe_seen = 1'b0;
    cmd(OP_SIGNATURE, 32, 8'h00);
    check({7'h00, oe_seen}, 8'h00);
    write_in_progress = 1'b0;
    pulse_soft();
    rd_rep(OP_RDBACK_EXT, 0, {DS_EIGHTH, e, 2'h0});
    cmd(OP_CLEAR_EXT_ERR, 0, 8'h00);
    rd_rep(OP_RDBACK_EXT, 0, {DS_EIGHTH, 5'h00});
    rd_rep(OP_SIGNATURE, 3, SIG);
    qpi = 1'b1;
    rd_rep(OP_SIGNATURE, 3, SIG);
    qpi = 1'b0;
    cmd(OP_SET_RP_VOL_A, 8, 8'h00);
    hold_n = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    check({7'h00, hold_act}, 8'h01);
    hold_n = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    cmd(OP_SET_RP_VOL_A, 8, 8'h80);
    hold_n = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    hold_n = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    check(rparams, 8'h05);
    check(rparams_b, 8'h80);
    ded_n = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    ded_n = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    check(rparams_b, 8'h05);
    // Wrap setting is rewritten before each read and kept across it.
    for (int k = 0; k < 10; k++) begin
      rp = (k == 0) ? 8'h04 : 8'($random(seed)) & 8'h7F;
      a = (k == 0) ? 24'h00_00FE : 24'($random(seed));
      op = k[0] ? OP_FAST_READ : OP_READ;
      cmd(OP_SET_RP_VOL_A, 8, rp);
      host.start();
      host.xfer(1'b0, 8, op, rx);
      for (int b = 2; b >= 0; b--) host.xfer(1'b0, 8, a[8 * b +: 8], rx);
      if (k[0]) host.xfer(1'b0, (rp[6:3] == 4'h0) ? 8 : rp[6:3], 8'h00, rx);
      for (int n = 0; n < 12; n++) begin
        host.xfer(1'b0, 8, 8'h00, rx);
        check(rx, pat(a));
        a = nxt(a, rp[2:0]);
      end
      host.stop();
    end
    conclude();
  end

endmodule : tb_top
